// *** rtl/dual_timer_counter.sv ***
// Purpose: two timer/counters with overflow flags and irq requests
// Assumes: count pins synchronous to ref_clk, one-cycle acks
// Notes:   a byte write replaces that byte's count step
`timescale 1ns/1ps
module dual_timer_counter (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire timer_pkg::bus_req_t busReq,
  output logic [7:0]              rdata,
  input  wire logic               timer0_count_pin,
  input  wire logic               timer1_count_pin,
  input  wire logic               timer0IrqAck,
  input  wire logic               timer1IrqAck,
  output logic                    timer0IrqReq,
  output logic                    timer1IrqReq,
  output logic                    timer0IrqHigh,
  output logic                    timer1IrqHigh
);
  logic [7:0]        mode_reg;
  logic [7:0]        prescale_reg;
  logic [7:0]        irqEn_reg;
  logic [7:0]        irqPri_reg;
  logic [1:0]        run_reg;
  logic [1:0]        flag_reg;
  logic [1:0]        flag_next;
  logic [1:0]        pinPrev_reg;
  logic [1:0]        pin;
  logic [1:0]        fall;
  logic [1:0]        tick;
  logic [1:0]        inc;
  logic [1:0]        ovf;
  logic [3:0]        pre_reg;
  logic              tick12;
  logic              split0;
  logic              splitHiInc;
  logic              splitHiOvf;
  logic              ctlWr;
  logic              wrCnt;
  logic [7:0]        rdata_reg;
  logic              irq0_reg;
  logic              irq1_reg;
  timer_pkg::tcfg_t  cfg [2];
  timer_pkg::count_t cnt_reg [2];
  timer_pkg::step_t  step [2];

  function automatic timer_pkg::step_t stepCount(
    timer_pkg::tmode_t m,
    timer_pkg::count_t c,
    logic              incA,
    logic              incB
  );
    timer_pkg::step_t s;
    s.c     = c;
    s.ovfLo = 1'b0;
    s.ovfHi = 1'b0;
    unique case (m)
      timer_pkg::MODE_13BIT: begin
        if (incA) begin
          // upper low-byte bits left as they are
          {s.c.hi, s.c.lo[4:0]} = {c.hi, c.lo[4:0]} + 13'h0001;
          s.ovfLo = &{c.hi, c.lo[4:0]};
        end
      end
      timer_pkg::MODE_16BIT: begin
        if (incA) begin
          s.c     = timer_pkg::count_t'(c + 16'h0001);
          s.ovfLo = &c;
        end
      end
      timer_pkg::MODE_RELOAD: begin
        if (incA) begin
          // high byte untouched: it is the reload value
          s.c.lo  = (&c.lo) ? c.hi : c.lo + 8'h01;
          s.ovfLo = &c.lo;
        end
      end
      timer_pkg::MODE_SPLIT: begin
        if (incA) begin
          s.c.lo  = c.lo + 8'h01;
          s.ovfLo = &c.lo;
        end
        if (incB) begin
          s.c.hi  = c.hi + 8'h01;
          s.ovfHi = &c.hi;
        end
      end
    endcase
    return s;
  endfunction

  assign pin    = {timer1_count_pin, timer0_count_pin};
  assign ctlWr  = busReq.wr && busReq.addr == timer_pkg::ADDR_CONTROL;
  assign wrCnt  = busReq.wr
                && busReq.addr >= timer_pkg::ADDR_T0LO
                && busReq.addr <= timer_pkg::ADDR_T1HI;
  assign tick12 = pre_reg == timer_pkg::PRESCALE_LAST;

  // one shared divider keeps both timers phase aligned
  always_ff @(posedge ref_clk) begin
    if (rst || tick12) begin
      pre_reg <= 4'h0;
    end else begin
      pre_reg <= pre_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinPrev_reg <= 2'h3;
    end else begin
      pinPrev_reg <= pin;
    end
  end

  assign split0 = cfg[0].mode == timer_pkg::MODE_SPLIT;
  // split high byte: timer1 run bit, timer0 rate, never the pin
  assign splitHiInc = split0 && run_reg[1] && tick[0];
  assign splitHiOvf = step[0].ovfHi;

  for (genvar i = 0; i < 2; i++) begin : g_timer
    localparam logic [7:0] LO_ADDR =
      (i == 0) ? timer_pkg::ADDR_T0LO : timer_pkg::ADDR_T1LO;
    localparam logic [7:0] HI_ADDR =
      (i == 0) ? timer_pkg::ADDR_T0HI : timer_pkg::ADDR_T1HI;
    localparam int MODE_POS =
      (i == 0) ? timer_pkg::MODE_POS0 : timer_pkg::MODE_POS1;
    logic halt;
    logic incB;
    assign cfg[i]  = timer_pkg::tcfg_t'(mode_reg[MODE_POS +: 3]);
    assign fall[i] = pinPrev_reg[i] & ~pin[i];
    assign tick[i] = prescale_reg[i] | tick12;
    if (i == 1) begin : g_t1
      // timer1 has no split mode of its own
      assign halt = split0
                  || cfg[1].mode == timer_pkg::MODE_SPLIT;
      assign incB = 1'b0;
    end else begin : g_t0
      assign halt = 1'b0;
      assign incB = splitHiInc;
    end
    // run only gates: count is held, never cleared
    assign inc[i] = run_reg[i] && !halt
                  && (cfg[i].cs ? fall[i] : tick[i]);
    assign step[i] = stepCount(cfg[i].mode, cnt_reg[i], inc[i], incB);
    assign ovf[i]  = step[i].ovfLo;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        cnt_reg[i] <= '0;
      end else begin
        cnt_reg[i].lo <= (busReq.wr && busReq.addr == LO_ADDR)
                       ? busReq.wdata : step[i].c.lo;
        cnt_reg[i].hi <= (busReq.wr && busReq.addr == HI_ADDR)
                       ? busReq.wdata : step[i].c.hi;
      end
    end
  end

  // set wins over a software write or an ack in the same cycle
  always_comb begin
    logic [1:0] held;
    held    = flag_reg;
    if (ctlWr) begin
      held = {busReq.wdata[timer_pkg::CTL_FLAG1],
              busReq.wdata[timer_pkg::CTL_FLAG0]};
    end
    flag_next    = held & ~{timer1IrqAck, timer0IrqAck};
    flag_next[0] = flag_next[0] | ovf[0];
    flag_next[1] = flag_next[1] | ovf[1] | splitHiOvf;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_reg <= 2'h0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_reg <= 2'h0;
    end else if (ctlWr) begin
      run_reg <= {busReq.wdata[timer_pkg::CTL_RUN1],
                  busReq.wdata[timer_pkg::CTL_RUN0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg     <= timer_pkg::REG_RESET;
      prescale_reg <= timer_pkg::REG_RESET;
      irqEn_reg    <= timer_pkg::REG_RESET;
      irqPri_reg   <= timer_pkg::REG_RESET;
    end else if (busReq.wr) begin
      unique case (busReq.addr)
        timer_pkg::ADDR_MODE:
          mode_reg <= busReq.wdata & timer_pkg::MODE_MASK;
        timer_pkg::ADDR_PRESCALE:
          prescale_reg <= busReq.wdata & timer_pkg::PRE_MASK;
        timer_pkg::ADDR_IRQEN:
          irqEn_reg <= busReq.wdata & timer_pkg::EN_MASK;
        timer_pkg::ADDR_IRQPRI:
          irqPri_reg <= busReq.wdata & timer_pkg::PRI_MASK;
        default: begin
        end
      endcase
    end
  end

  // unmapped and write-only-free reads answer zero
  always_ff @(posedge ref_clk) begin
    if (rst || !busReq.rd) begin
      rdata_reg <= 8'h00;
    end else begin
      unique case (busReq.addr)
        timer_pkg::ADDR_CONTROL:
          rdata_reg <= {flag_reg[1], run_reg[1], flag_reg[0],
                        run_reg[0], 4'h0};
        timer_pkg::ADDR_MODE:     rdata_reg <= mode_reg;
        timer_pkg::ADDR_T0LO:     rdata_reg <= cnt_reg[0].lo;
        timer_pkg::ADDR_T1LO:     rdata_reg <= cnt_reg[1].lo;
        timer_pkg::ADDR_T0HI:     rdata_reg <= cnt_reg[0].hi;
        timer_pkg::ADDR_T1HI:     rdata_reg <= cnt_reg[1].hi;
        timer_pkg::ADDR_PRESCALE: rdata_reg <= prescale_reg;
        timer_pkg::ADDR_IRQEN:    rdata_reg <= irqEn_reg;
        timer_pkg::ADDR_IRQPRI:   rdata_reg <= irqPri_reg;
        default:                  rdata_reg <= 8'h00;
      endcase
    end
  end

  // one cycle behind the flag, so outputs stay registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
    end else begin
      irq0_reg <= flag_reg[0] && irqEn_reg[timer_pkg::IRQ_TMR0]
                && irqEn_reg[timer_pkg::IRQ_GLOBAL];
      irq1_reg <= flag_reg[1] && irqEn_reg[timer_pkg::IRQ_TMR1]
                && irqEn_reg[timer_pkg::IRQ_GLOBAL];
    end
  end

  assign rdata         = rdata_reg;
  assign timer0IrqReq  = irq0_reg;
  assign timer1IrqReq  = irq1_reg;
  assign timer0IrqHigh = irqPri_reg[timer_pkg::IRQ_TMR0];
  assign timer1IrqHigh = irqPri_reg[timer_pkg::IRQ_TMR1];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  prescale_period_a: assert property (
    tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
    else $error("divide-by-twelve tick period wrong");

  fast_step_a: assert property (
    run_reg[0] && !cfg[0].cs && prescale_reg[0] && !wrCnt
    && cfg[0].mode == timer_pkg::MODE_16BIT
    |=> cnt_reg[0] == timer_pkg::count_t'($past(cnt_reg[0]) + 16'h0001))
    else $error("timer0 full-rate step missing");

  slow_hold_a: assert property (
    run_reg[0] && !cfg[0].cs && !prescale_reg[0] && !tick12 && !wrCnt
    |=> $stable(cnt_reg[0]))
    else $error("timer0 counted between prescale ticks");

  ovf13_flag_a: assert property (
    cfg[0].mode == timer_pkg::MODE_13BIT && inc[0] && !wrCnt
    && cnt_reg[0].hi == 8'hFF && cnt_reg[0].lo[4:0] == 5'h1F
    |=> flag_reg[0] && cnt_reg[0].hi == 8'h00
    && cnt_reg[0].lo[4:0] == 5'h00)
    else $error("13-bit overflow not flagged");

  edge_count_a: assert property (
    run_reg[0] && cfg[0].cs && fall[0] && !wrCnt
    && cfg[0].mode == timer_pkg::MODE_16BIT
    |=> cnt_reg[0] == timer_pkg::count_t'($past(cnt_reg[0]) + 16'h0001))
    else $error("falling edge not counted");

  stopped_hold_a: assert property (
    !run_reg[0] && !split0 && !wrCnt |=> $stable(cnt_reg[0]))
    else $error("stopped timer0 changed");

  reload_copy_a: assert property (
    cfg[0].mode == timer_pkg::MODE_RELOAD && inc[0] && !wrCnt
    && cnt_reg[0].lo == 8'hFF
    |=> flag_reg[0] && cnt_reg[0].lo == $past(cnt_reg[0].hi)
    && $stable(cnt_reg[0].hi))
    else $error("reload from high byte failed");

  split_high_a: assert property (
    splitHiInc && cnt_reg[0].hi == 8'hFF && !wrCnt
    |=> flag_reg[1] && cnt_reg[0].hi == 8'h00)
    else $error("split high overflow missed timer1 flag");

  t1_halt_a: assert property (
    (split0 || cfg[1].mode == timer_pkg::MODE_SPLIT) && !wrCnt
    |=> $stable(cnt_reg[1]))
    else $error("timer1 counted while halted");

  ack_clear_a: assert property (
    timer0IrqAck && !ovf[0] && !ctlWr |=> !flag_reg[0])
    else $error("ack did not clear timer0 flag");

  irq_gate_a: assert property (
    !irqEn_reg[timer_pkg::IRQ_TMR1] ##1 !irqEn_reg[timer_pkg::IRQ_TMR1]
    |-> !timer1IrqReq)
    else $error("disabled timer1 interrupt raised");

  ovf0_c: cover property (ovf[0] ##[1:4] timer0IrqReq);
  reload_c: cover property (
    cfg[0].mode == timer_pkg::MODE_RELOAD && ovf[0]);
  split_c: cover property (splitHiOvf ##[1:4] timer1IrqReq);
  edge_c: cover property (cfg[1].cs && inc[1]);
endmodule // dual_timer_counter

// *** rtl/timer_pkg.sv ***
// Purpose: constants and types of the dual timer/counter
// Assumes: 8-bit register port, one system clock
// Notes:   mode field encodes {count select, mode[1:0]}
// Summary of operation
// - timer1 timer source: clock/12 when prescale bit 1 is 0, full clock when 1
// - prescale bit 0 picks timer0 source: 0 is clock/12, 1 full clock
// - enable bit 3 gates timer1 interrupt, bit 1 gates timer0
// - priority bit 3 sets timer1 level, bit 1 sets timer0 level
// - mode 0 is 13 bits: high byte plus low byte bits 4..0
// - low byte bits 7..5 are undefined in mode 0, ignored by software
// - overflow sets the flag and requests an enabled interrupt
// - counter select 1 counts falling edges of the count pin
// - counter select 0 counts the prescaled system clock
// - run bit resumes from the held count; software preloads it
// - mode 1 is mode 0 with all eight low bits: 16-bit counter
// - mode 2 low byte overflow sets flag and reloads from high byte
// - mode 2 reload byte is kept; software sets low byte first
// - mode 3 splits timer0; low byte uses timer0 controls and flag
// - split high byte runs on timer1 run bit, sets timer1 flag
// - split high byte always counts the prescaled clock
// - timer1 counter stops while timer0 is in mode 3
// - timer1 has 13-bit, 16-bit and reload modes, no split
// - timer1 counts falling edges of its pin when select is 1
// - timer1 mode 2 reloads low from high, high unchanged
// - timer1 run bit resumes without clearing; software preloads
// - timer1 mode 3 halts timer1
// - mode register: timer0 in bits 0..2, timer1 in bits 4..6
// - flags set on overflow, cleared when the interrupt is taken
package timer_pkg;
  localparam logic [7:0] ADDR_CONTROL  = 8'h88;
  localparam logic [7:0] ADDR_MODE     = 8'h89;
  localparam logic [7:0] ADDR_T0LO     = 8'h8A;
  localparam logic [7:0] ADDR_T1LO     = 8'h8B;
  localparam logic [7:0] ADDR_T0HI     = 8'h8C;
  localparam logic [7:0] ADDR_T1HI     = 8'h8D;
  localparam logic [7:0] ADDR_PRESCALE = 8'h8E;
  localparam logic [7:0] ADDR_IRQEN    = 8'hA8;
  localparam logic [7:0] ADDR_IRQPRI   = 8'hB8;
  localparam int CTL_FLAG1  = 7;
  localparam int CTL_RUN1   = 6;
  localparam int CTL_FLAG0  = 5;
  localparam int CTL_RUN0   = 4;
  localparam int MODE_POS0  = 0;
  localparam int MODE_POS1  = 4;
  localparam int IRQ_TMR0   = 1;
  localparam int IRQ_TMR1   = 3;
  localparam int IRQ_GLOBAL = 7;
  localparam logic [7:0] MODE_MASK = 8'h77;
  localparam logic [7:0] PRE_MASK  = 8'h03;
  localparam logic [7:0] EN_MASK   = 8'h8A;
  localparam logic [7:0] PRI_MASK  = 8'h0A;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] PRESCALE_LAST = 4'hB;
  typedef enum logic [1:0] {
    MODE_13BIT, MODE_16BIT, MODE_RELOAD, MODE_SPLIT
  } tmode_t;
  typedef struct packed {
    logic   cs;
    tmode_t mode;
  } tcfg_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } count_t;
  typedef struct packed {
    count_t c;
    logic   ovfLo;
    logic   ovfHi;
  } step_t;
endpackage

// *** verification/dual_timer_counter_tb_top.sv ***
// Purpose: self-checking bench of the dual timer/counter
// Assumes: one-cycle register strobes, pins idle high
// Notes:   full clock prescale in the overflow and split tests
`timescale 1ns/1ps
module dual_timer_counter_tb_top;
  logic                ref_clk;
  logic                rst;
  timer_pkg::bus_req_t busReq;
  logic [7:0]          rdata;
  logic                pin0;
  logic                pin1;
  logic                fire;
  logic [3:0]          lowLen;
  logic                ack0;
  logic                ack1;
  logic [3:0]          irq;
  int                  n_fail;
  int                  n_checks;

  dual_timer_counter dual_timer_counter_i (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .busReq          (busReq),
    .rdata           (rdata),
    .timer0_count_pin(pin0),
    .timer1_count_pin(pin1),
    .timer0IrqAck    (ack0),
    .timer1IrqAck    (ack1),
    .timer0IrqReq    (irq[0]),
    .timer1IrqReq    (irq[1]),
    .timer0IrqHigh   (irq[2]),
    .timer1IrqHigh   (irq[3])
  );
  pulse_source src0 (.ref_clk(ref_clk), .fire(fire), .lowLen(lowLen),
                     .pin(pin0));
  pulse_source src1 (.ref_clk(ref_clk), .fire(fire), .lowLen(lowLen),
                     .pin(pin1));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    busReq.wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input logic [7:0] m = 8'hFF);
    logic [7:0] got;
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    busReq.rd <= 1'b0;
    // data stand only in this cycle; take them mid-cycle
    @(negedge ref_clk);
    got = rdata;
    @(posedge ref_clk);
    check($sformatf("reg %h", a), exp & m, got & m);
  endtask

  // 120 counting edges: exact for full clock and for divide by 12
  task automatic window(input logic [7:0] run);
    wr(timer_pkg::ADDR_CONTROL, run);
    repeat (118) @(posedge ref_clk);
    wr(timer_pkg::ADDR_CONTROL, 8'h00);
  endtask

  task automatic measure(input bit t, input logic [7:0] pre,
                         input logic [7:0] exp);
    logic [7:0] lo;
    lo = t ? timer_pkg::ADDR_T1LO : timer_pkg::ADDR_T0LO;
    wr(timer_pkg::ADDR_MODE, 8'h11);
    wr(timer_pkg::ADDR_PRESCALE, pre);
    wr(lo, 8'h00);
    window(t ? 8'h40 : 8'h10);
    rd(lo, exp);
    window(t ? 8'h40 : 8'h10);
    rd(lo, 8'(exp * 2));
  endtask

  task automatic ovf(input bit t, input logic [1:0] md, input bit e);
    logic [7:0] lo, hi, mv, rb, hv;
    lo = t ? timer_pkg::ADDR_T1LO : timer_pkg::ADDR_T0LO;
    hi = t ? timer_pkg::ADDR_T1HI : timer_pkg::ADDR_T0HI;
    mv = t ? {2'b00, md, 4'h0} : {6'h00, md};
    rb = t ? 8'h40 : 8'h10;
    hv = md[1] ? 8'h40 : 8'hFF;
    wr(timer_pkg::ADDR_IRQEN, (e ^ t) ? 8'h82 : 8'h88);
    wr(timer_pkg::ADDR_PRESCALE, 8'h03);
    wr(timer_pkg::ADDR_MODE, mv);
    wr(lo, md == 2'd0 ? 8'h1E : 8'hFE);
    wr(hi, hv);
    wr(timer_pkg::ADDR_CONTROL, rb);
    // stop by pin counting, not by run bit, so flags are kept
    wr(timer_pkg::ADDR_MODE, mv | 8'h44);
    rd(timer_pkg::ADDR_CONTROL, rb | (rb << 1));
    rd(hi, md[1] ? hv : 8'h00);
    rd(lo, md[1] ? hv : 8'h00, md == 2'd0 ? 8'h1F : 8'hFF);
    check("irq", {7'h0, e}, {7'h0, irq[t]});
    {ack1, ack0} <= t ? 2'b10 : 2'b01;
    @(posedge ref_clk);
    {ack1, ack0} <= 2'b00;
    repeat (3) @(posedge ref_clk);
    check("irq", 8'h00, {7'h0, irq[t]});
    rd(timer_pkg::ADDR_CONTROL, rb);
    wr(timer_pkg::ADDR_CONTROL, 8'h00);
  endtask

  task automatic pulse(input logic [3:0] len);
    fire <= 1'b1;
    lowLen <= len;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (len + 3) @(posedge ref_clk);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    logic [7:0] adr [5];
    logic [7:0] msk [5];
    adr = '{timer_pkg::ADDR_MODE, timer_pkg::ADDR_PRESCALE,
            timer_pkg::ADDR_IRQEN, timer_pkg::ADDR_IRQPRI, 8'h90};
    msk = '{8'h77, 8'h03, 8'h8A, 8'h0A, 8'h00};
    n_fail = 0;
    n_checks = 0;
    rst = 1'b1;
    busReq = '0;
    fire = 1'b0;
    lowLen = 4'h1;
    ack0 = 1'b0;
    ack1 = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      rd(adr[i], 8'h00);
      wr(adr[i], 8'hFF);
      rd(adr[i], msk[i]);
    end
    @(posedge ref_clk);
    check("high", 8'h03, {6'h0, irq[3:2]});
    wr(timer_pkg::ADDR_IRQPRI, 8'h02);
    @(posedge ref_clk);
    check("high", 8'h01, {6'h0, irq[3:2]});
    $display("test registers done");
    measure(1'b0, 8'h01, 8'h78);
    measure(1'b0, 8'h02, 8'h0A);
    measure(1'b1, 8'h02, 8'h78);
    measure(1'b1, 8'h01, 8'h0A);
    $display("test prescale done");
    for (int t = 0; t < 2; t++)
      for (int m = 0; m < 3; m++)
        ovf(t[0], m[1:0], m != 1);
    $display("test overflow done");
    wr(timer_pkg::ADDR_MODE, 8'h55);
    wr(timer_pkg::ADDR_T0LO, 8'h00);
    wr(timer_pkg::ADDR_T1LO, 8'h00);
    wr(timer_pkg::ADDR_CONTROL, 8'h50);
    for (int k = 1; k < 4; k++)
      pulse(4'(k * 2 - 1));
    wr(timer_pkg::ADDR_CONTROL, 8'h00);
    pulse(4'h2);
    rd(timer_pkg::ADDR_T0LO, 8'h03);
    rd(timer_pkg::ADDR_T1LO, 8'h03);
    $display("test counter done");
    wr(timer_pkg::ADDR_MODE, 8'h13);
    wr(timer_pkg::ADDR_T0HI, 8'h00);
    wr(timer_pkg::ADDR_T0LO, 8'h00);
    wr(timer_pkg::ADDR_T1LO, 8'h00);
    window(8'h40);
    rd(timer_pkg::ADDR_T0HI, 8'h78);
    rd(timer_pkg::ADDR_T0LO, 8'h00);
    rd(timer_pkg::ADDR_T1LO, 8'h00);
    wr(timer_pkg::ADDR_MODE, 8'h17);
    window(8'h40);
    rd(timer_pkg::ADDR_T0HI, 8'hF0);
    wr(timer_pkg::ADDR_T0HI, 8'hFE);
    wr(timer_pkg::ADDR_CONTROL, 8'h40);
    wr(timer_pkg::ADDR_MODE, 8'h55);
    rd(timer_pkg::ADDR_CONTROL, 8'hC0);
    rd(timer_pkg::ADDR_T0HI, 8'h00);
    check("irq", 8'h01, {7'h0, irq[1]});
    wr(timer_pkg::ADDR_CONTROL, 8'h00);
    wr(timer_pkg::ADDR_MODE, 8'h30);
    wr(timer_pkg::ADDR_CONTROL, 8'h40);
    repeat (20) @(posedge ref_clk);
    rd(timer_pkg::ADDR_T1LO, 8'h00);
    // flags are writable from software as well
    wr(timer_pkg::ADDR_CONTROL, 8'hA0);
    rd(timer_pkg::ADDR_CONTROL, 8'hA0);
    wr(timer_pkg::ADDR_CONTROL, 8'h00);
    rd(timer_pkg::ADDR_CONTROL, 8'h00);
    $display("test split done");
    end_of_test();
  end
endmodule // dual_timer_counter_tb_top

// *** verification/pulse_source.sv ***
// Purpose: external pulse source for one timer count pin
// Assumes: pin idles high, as with a pull-up
// Notes:   low phase set per pulse, so slow sources are covered
`timescale 1ns/1ps
module pulse_source (
  input  wire logic       ref_clk,
  input  wire logic       fire,
  input  wire logic [3:0] lowLen,
  output logic            pin
);
  logic [3:0] lowCnt;
  initial begin
    pin = 1'b1;
    lowCnt = 4'h0;
  end
  // one falling edge per request, then back to idle high
  always @(posedge ref_clk) begin
    if (fire && lowCnt == 4'h0) begin
      pin <= 1'b0;
      lowCnt <= lowLen;
    end else if (lowCnt == 4'h1) begin
      pin <= 1'b1;
      lowCnt <= 4'h0;
    end else if (lowCnt != 4'h0) begin
      lowCnt <= lowCnt - 4'h1;
    end
  end
endmodule // pulse_source
